//--- lem_cell.sv
// Configurable logic cell: table, register, chains, async control
//
// Notes on behaviour
// - Four modes: normal, arithmetic, up/down counter, clearable counter.
// - Six logic inputs plus clock, clear and preset for the register.
// - Register has a synchronous clock enable, optionally the first data input.
// - Normal mode uses a four-input table; carry-in may replace third input.
// - Table output may AND with cascade-in; register or table drives both.
// - Packing registers fourth input while table computes three-input function, four-input with pack_d4_lut set.
// - Packed register keeps controls; local and global outputs may swap.
// - Arithmetic mode: two three-input tables give sum and carry-out.
// - Arithmetic mode may use cascade chain together with carry chain.
// - Up/down counter: count enable, clock enable, direction, load selector.
// - Counter modes accept asynchronous load through clear and preset.
// - Clearable counter: cascade-in clears synchronously, selector ANDed low.
// - Emulated tri-state bus: contention gives low, no driver gives high.
// - Register clear and preset are active low; unused ones stay high.
// - Six asynchronous clear/preset modes.
// - Chip-wide reset overrides every other control.
// - Clear mode: either control line clears; preset held inactive.
// - Preset mode: control line one loads a one.
// - Clear-and-preset: line one presets, line two clears.
// - Load-with-clear: line one loads third input, line two clears.
// - Load-with-preset: line two presets, line one loads third input.
// - Load-only: line one copies third input into register.
//
// The implementer's own choices: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`include "lem_params.svh"

module lem_cell
  import lem_pkg::*;
#(
  parameter int TRI_N = 4,
  parameter int ADDR_W = 4,
  parameter logic RESET_VAL = `LEM_CHIP_RESET_VAL
)
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire lem_data_s data_in,
  input wire logic carry_in,
  input wire logic cascade_in,
  input wire logic block_control_line_one,
  input wire logic block_control_line_two,
  input wire logic [TRI_N-1:0] tri_data,
  input wire logic [TRI_N-1:0] tri_en,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  output logic local_out,
  output logic global_out,
  output logic carry_out,
  output logic cascade_out,
  output logic tri_bus
);

  // ==========================================================
  // Helpers

  function automatic logic lut_pick(input logic [15:0] mask,
                                    input logic [3:0] idx);
    lut_pick = mask[idx];
  endfunction

  function automatic logic addr_is(input logic [ADDR_W-1:0] a,
                                   input logic [3:0] off);
    addr_is = (a == ADDR_W'(off));
  endfunction

  // ==========================================================
  // Register port

  logic [`LEM_CFG_W-1:0] cfg_reg;
  logic [`LEM_CFG_W-1:0] cfg_next;
  logic [`LEM_LUT_W-1:0] lut_reg;
  logic [`LEM_LUT_W-1:0] lut_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic [`LEM_STAT_W-1:0] status;

  always_comb
  begin
    cfg_next = cfg_reg;
    lut_next = lut_reg;
    rdata_next = 32'h0000_0000;
    if (reg_write && addr_is(reg_addr, `LEM_ADDR_CFG))
    begin
      cfg_next = reg_wdata[`LEM_CFG_W-1:0];
    end
    if (reg_write && addr_is(reg_addr, `LEM_ADDR_LUT))
    begin
      lut_next = reg_wdata[`LEM_LUT_W-1:0];
    end
    // Unmapped reads return zero
    if (reg_read)
    begin
      if (addr_is(reg_addr, `LEM_ADDR_CFG))
      begin
        rdata_next = {{(32-`LEM_CFG_W){1'b0}}, cfg_reg};
      end
      else if (addr_is(reg_addr, `LEM_ADDR_LUT))
      begin
        rdata_next = {{(32-`LEM_LUT_W){1'b0}}, lut_reg};
      end
      else if (addr_is(reg_addr, `LEM_ADDR_STAT))
      begin
        rdata_next = {{(32-`LEM_STAT_W){1'b0}}, status};
      end
    end
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cfg_reg <= `LEM_CFG_RESET;
      lut_reg <= `LEM_LUT_RESET;
      rdata_reg <= 32'h0000_0000;
    end
    else
    begin
      cfg_reg <= cfg_next;
      lut_reg <= lut_next;
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata = rdata_reg;

  // ==========================================================
  // Configuration decode

  lem_mode_e mode;
  lem_cp_e cp_mode;
  logic ena_on_d1;
  logic cin_for_d3;
  logic casc_en;
  logic pack_en;
  logic pack_swap;
  logic pack_d4_lut;
  logic reg_drives;

  assign mode = lem_mode_e'(cfg_reg[`LEM_F_MODE]);
  assign cp_mode = lem_cp_e'(cfg_reg[`LEM_F_CP]);
  assign ena_on_d1 = cfg_reg[`LEM_F_ENA_D1];
  assign cin_for_d3 = cfg_reg[`LEM_F_CIN_D3];
  assign casc_en = cfg_reg[`LEM_F_CASC];
  assign pack_en = cfg_reg[`LEM_F_PACK];
  assign pack_swap = cfg_reg[`LEM_F_SWAP];
  assign pack_d4_lut = cfg_reg[`LEM_F_PACK4];
  assign reg_drives = cfg_reg[`LEM_F_REGOUT];

  // ==========================================================
  // Datapath per mode

  logic reg_q;
  logic q_eff;
  logic ce;
  logic lut_out;
  logic sum_out;
  logic reg_d;
  logic cnt_bit;
  logic load_sel;
  logic [3:0] lut_idx;

  // Counter modes: d2 count enable, d4 load select, d3 load data
  always_comb
  begin
    lut_idx = '0;
    lut_out = 1'b0;
    sum_out = 1'b0;
    reg_d = reg_q;
    cnt_bit = reg_q;
    load_sel = reg_q;
    carry_out = 1'b0;
    cascade_out = 1'b1;
    local_out = q_eff;
    global_out = q_eff;
    ce = ena_on_d1 ? data_in.first_data_input : 1'b1;
    case (mode)
      lem_normal:
      begin
        lut_idx = {data_in.fourth_data_input,
                   cin_for_d3 ? carry_in : data_in.third_data_input,
                   data_in.second_data_input, data_in.first_data_input};
        if (pack_en && !pack_d4_lut)
        begin
          lut_idx[3] = 1'b0;
        end
        lut_out = lut_pick(lut_reg, lut_idx);
        cascade_out = casc_en ? (lut_out & cascade_in) : lut_out;
        if (pack_en)
        begin
          reg_d = data_in.fourth_data_input;
          local_out = pack_swap ? q_eff : cascade_out;
          global_out = pack_swap ? cascade_out : q_eff;
        end
        else
        begin
          reg_d = cascade_out;
          local_out = reg_drives ? q_eff : cascade_out;
          global_out = local_out;
        end
      end
      lem_arith:
      begin
        lut_idx = {1'b0, carry_in, data_in.second_data_input,
                   data_in.first_data_input};
        sum_out = lut_pick(lut_reg, lut_idx);
        carry_out = lut_pick(lut_reg, lut_idx | `LEM_CARRY_BASE);
        cascade_out = casc_en ? (sum_out & cascade_in) : sum_out;
        reg_d = cascade_out;
        local_out = reg_drives ? q_eff : cascade_out;
        global_out = local_out;
      end
      lem_updown:
      begin
        cnt_bit = reg_q ^ (data_in.second_data_input & carry_in);
        carry_out = carry_in & (cascade_in ? reg_q : ~reg_q);
        load_sel = data_in.fourth_data_input ?
                   data_in.third_data_input : cnt_bit;
        reg_d = load_sel;
      end
      lem_clrcnt:
      begin
        cnt_bit = reg_q ^ (data_in.second_data_input & carry_in);
        carry_out = carry_in & reg_q;
        load_sel = data_in.fourth_data_input ?
                   data_in.third_data_input : cnt_bit;
        reg_d = load_sel & ~cascade_in;
      end
      default:
      begin
        reg_d = reg_q;
      end
    endcase
  end

  // ==========================================================
  // Asynchronous clear, preset and load

  lem_async_s ctl;
  logic c1;
  logic c2;
  logic d3;

  assign c1 = block_control_line_one;
  assign c2 = block_control_line_two;
  assign d3 = data_in.third_data_input;

  // Works the same in every mode, so counters load without the table
  always_comb
  begin
    ctl = '{clr_n: 1'b1, pre_n: 1'b1};
    case (cp_mode)
      lem_cp_clear:
      begin
        ctl.clr_n = ~(c1 | c2);
      end
      lem_cp_preset:
      begin
        ctl.pre_n = ~c1;
      end
      lem_cp_clr_pre:
      begin
        ctl.pre_n = ~c1;
        ctl.clr_n = ~c2;
      end
      lem_cp_load_clr:
      begin
        ctl.pre_n = ~(c1 & d3);
        ctl.clr_n = ~((c1 & ~d3) | c2);
      end
      lem_cp_load_pre:
      begin
        // Stored inverted in silicon; seen from outside it loads d3
        ctl.pre_n = ~((c1 & d3) | c2);
        ctl.clr_n = ~(c1 & ~d3 & ~c2);
      end
      lem_cp_load:
      begin
        ctl.pre_n = ~(c1 & d3);
        ctl.clr_n = ~(c1 & ~d3);
      end
      default:
      begin
        ctl = '{clr_n: 1'b1, pre_n: 1'b1};
      end
    endcase
  end

  // ==========================================================
  // Cell register

  logic q_next;

  // Async controls act on the output at once and are held by the flop
  // at the next edge; keeps the async reset a pure constant.
  always_comb
  begin
    if (!ctl.clr_n)
    begin
      q_next = 1'b0;
    end
    else if (!ctl.pre_n)
    begin
      q_next = 1'b1;
    end
    else if (ce)
    begin
      q_next = reg_d;
    end
    else
    begin
      q_next = reg_q;
    end
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      reg_q <= RESET_VAL;
    end
    else
    begin
      reg_q <= q_next;
    end
  end

  always_comb
  begin
    if (!reset_n)
    begin
      q_eff = RESET_VAL;
    end
    else if (!ctl.clr_n)
    begin
      q_eff = 1'b0;
    end
    else if (!ctl.pre_n)
    begin
      q_eff = 1'b1;
    end
    else
    begin
      q_eff = reg_q;
    end
  end

  assign status = {cascade_out, carry_out, global_out, local_out, q_eff};

  // ==========================================================
  // Emulated internal tri-state bus

  logic [TRI_N-1:0] tri_hit;

  genvar gi;
  generate
    for (gi = 0; gi < TRI_N; gi++)
    begin : g_tri
      assign tri_hit[gi] = tri_en[gi] & tri_data[gi];
    end
  endgenerate

  // Contention resolves low, floating resolves high
  always_comb
  begin
    if (tri_en == '0)
    begin
      tri_bus = 1'b1;
    end
    else if ((tri_en & (tri_en - 1'b1)) != '0)
    begin
      tri_bus = 1'b0;
    end
    else
    begin
      tri_bus = |tri_hit;
    end
  end

  // ==========================================================
  // Checks

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);

  sequence s_quiet;
    ctl.clr_n && ctl.pre_n;
  endsequence

  sequence s_count_up;
    mode == lem_updown && ctl.clr_n && ctl.pre_n && ce
      && data_in.second_data_input && carry_in
      && !data_in.fourth_data_input;
  endsequence

  a_tri_contend: assert property (
    $countones(tri_en) > 1 |-> !tri_bus)
    else $error("tri bus not low under contention");

  a_tri_float: assert property (
    tri_en == '0 |-> tri_bus)
    else $error("tri bus not high when floating");

  a_both_zero: assert property (
    !ctl.clr_n && !ctl.pre_n |-> !q_eff ##1 !reg_q)
    else $error("clear with preset did not give zero");

  a_clear_mode: assert property (
    cp_mode == lem_cp_clear && (c1 || c2) |-> !q_eff && ctl.pre_n)
    else $error("clear mode did not clear");

  a_ce_hold: assert property (
    s_quiet ##0 !ce |=> reg_q == $past(reg_q))
    else $error("register moved without clock enable");

  a_clr_count: assert property (
    mode == lem_clrcnt && ce && cascade_in ##0 s_quiet |=> !reg_q)
    else $error("clearable counter did not clear");

  a_count_step: assert property (
    s_count_up |=> reg_q != $past(reg_q))
    else $error("counter bit did not toggle");

  a_load_only: assert property (
    cp_mode == lem_cp_load && c1 |-> q_eff == d3 ##1 reg_q == $past(d3))
    else $error("async load did not copy third input");

  a_arith_carry: assert property (
    mode == lem_arith |-> carry_out
      == lut_reg[{1'b1, carry_in, data_in.second_data_input,
                  data_in.first_data_input}])
    else $error("carry out does not follow carry table");

  a_cascade_and: assert property (
    mode == lem_normal && casc_en && !cascade_in |-> !cascade_out)
    else $error("cascade chain not ANDed");

  a_lut_read: assert property (
    reg_read && addr_is(reg_addr, `LEM_ADDR_LUT)
      |=> reg_rdata[`LEM_LUT_W-1:0] == $past(lut_reg))
    else $error("table register read back wrong");

endmodule

//--- lem_cell_tb_top.sv
// Self-checking bench for the configurable logic cell
`timescale 1ns/1ps
`include "lem_params.svh"

module lem_cell_tb_top
  import lem_pkg::*;
  ;

  // ==========
  // Stimulus and observed signals
  logic mclk, reset_n, cin, casc, l1, l2, wr_s, rd_s;
  lem_data_s din;
  logic [3:0] tdat, ten, addr;
  logic [31:0] wdat, rdat;
  logic lo, go, co, cso, tb;
  int n_mismatch, num_checks;

  // Async control table: {clear/preset mode, line one, line two,
  // third input, expected output}
  localparam logic [6:0] ROWS [14] = '{
    7'h08,
    7'h04,
    7'h1B,
    7'h2B,
    7'h26,
    7'h2E,
    7'h3B,
    7'h38,
    7'h36,
    7'h45,
    7'h4B,
    7'h48,
    7'h5B,
    7'h58
  };

  lem_cell #(.TRI_N(4), .ADDR_W(4)) uut (
    .mclk(mclk), .reset_n(reset_n), .data_in(din), .carry_in(cin),
    .cascade_in(casc), .block_control_line_one(l1),
    .block_control_line_two(l2), .tri_data(tdat), .tri_en(ten),
    .reg_addr(addr), .reg_wdata(wdat), .reg_write(wr_s), .reg_read(rd_s),
    .reg_rdata(rdat), .local_out(lo), .global_out(go), .carry_out(co),
    .cascade_out(cso), .tri_bus(tb)
  );

  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // ==========
  // Shared tasks
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    wdat <= d;
    wr_s <= 1'b1;
    @(posedge mclk);
    wr_s <= 1'b0;
    #1;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge mclk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge mclk);
    rd_s <= 1'b0;
    #1;
    chk(rdat, e);
  endtask

  task automatic setup(input logic [11:0] c, input logic [15:0] t);
    wr(`LEM_ADDR_CFG, {20'h0, c});
    wr(`LEM_ADDR_LUT, {16'h0, t});
  endtask

  task automatic drv(input logic [3:0] d, input logic c, input logic k);
    @(posedge mclk);
    din <= lem_data_s'(d);
    cin <= c;
    casc <= k;
    #1;
  endtask

  // ==========
  // Scenarios
  task automatic t_regs();
    rd(`LEM_ADDR_CFG, 32'h0);
    wr(`LEM_ADDR_LUT, 32'hABCD_1234);
    rd(`LEM_ADDR_LUT, 32'h0000_1234);
    wr(4'hC, 32'hFFFF_FFFF);
    rd(4'hC, 32'h0);
    rd(`LEM_ADDR_CFG, 32'h0);
  endtask

  task automatic t_norm();
    setup(12'h820, 16'hFF00);
    drv(4'b1000, 1'b0, 1'b0);
    cyc(2);
    chk(lo, 0);
    drv(4'b1001, 1'b0, 1'b0);
    cyc(1);
    chk(lo, 1);
    chk(go, 1);
    rd(`LEM_ADDR_STAT, 32'h0000_0017);
    setup(12'h040, 16'hF0F0);
    drv(4'b0000, 1'b1, 1'b0);
    chk(lo, 1);
    setup(12'h000, 16'hF0F0);
    chk(lo, 0);
    setup(12'h080, 16'hFFFF);
    chk(cso, 0);
    drv(4'b0000, 1'b0, 1'b1);
    chk(cso, 1);
  endtask

  task automatic t_arith();
    setup(12'h081, 16'hE896);
    for (int i = 0; i < 8; i++)
    begin
      drv({2'b00, i[1:0]}, i[2], 1'b1);
      chk(lo, ^i[2:0]);
      chk(co, (i[0] & i[1]) | (i[2] & (i[0] | i[1])));
      chk(cso, ^i[2:0]);
    end
  endtask

  task automatic t_pack();
    setup(12'h100, 16'h00FF);
    drv(4'b1000, 1'b0, 1'b0);
    chk(lo, 1);
    cyc(1);
    chk(go, 1);
    drv(4'b0000, 1'b0, 1'b0);
    cyc(1);
    chk(go, 0);
    setup(12'h500, 16'h00FF);
    drv(4'b1000, 1'b0, 1'b0);
    chk(lo, 0);
    setup(12'h300, 16'h00FF);
    drv(4'b0000, 1'b0, 1'b0);
    chk(go, 1);
    cyc(1);
    chk(lo, 0);
  endtask

  // Counting is held off while checking, save one enabled step; otherwise the bit keeps toggling
  task automatic t_count();
    setup(12'h802, 16'h0000);
    drv(4'b1000, 1'b0, 1'b0);
    cyc(1);
    chk(lo, 0);
    drv(4'b0000, 1'b1, 1'b0);
    chk(co, 1);
    drv(4'b0000, 1'b1, 1'b1);
    chk(co, 0);
    drv(4'b1100, 1'b0, 1'b0);
    cyc(1);
    chk(lo, 1);
    drv(4'b0010, 1'b1, 1'b1);
    chk(co, 1);
    cyc(1);
    chk(lo, 0);
    setup(12'h803, 16'h0000);
    drv(4'b1100, 1'b1, 1'b0);
    cyc(1);
    chk(lo, 1);
    chk(co, 1);
    drv(4'b1100, 1'b1, 1'b1);
    cyc(1);
    chk(lo, 0);
  endtask

  task automatic t_async();
    logic [6:0] r;
    for (int i = 0; i < 14; i++)
    begin
      r = ROWS[i];
      setup({1'b1, 6'h00, r[6:4], 2'b00}, r[0] ? 16'h0000 : 16'hFFFF);
      drv({1'b0, r[1], 2'b00}, 1'b0, 1'b0);
      cyc(1);
      chk(lo, !r[0]);
      @(posedge mclk);
      l1 <= r[3];
      l2 <= r[2];
      #1;
      chk(lo, r[0]);
      cyc(1);
      chk(lo, r[0]);
      @(posedge mclk);
      l1 <= 1'b0;
      l2 <= 1'b0;
    end
  endtask

  task automatic t_tri();
    int n;
    for (int e = 0; e < 16; e++)
    begin
      @(posedge mclk);
      ten <= e[3:0];
      tdat <= 4'h6;
      #1;
      n = $countones(e[3:0]);
      chk(tb, n == 0 ? 1 : n > 1 ? 0 : |(e[3:0] & 4'h6));
    end
  endtask

  // Chip-wide reset must win over an asserted preset
  task automatic t_rst();
    setup(12'h804, 16'h0000);
    @(posedge mclk);
    l1 <= 1'b1;
    din <= lem_data_s'(4'b0100);
    #1;
    chk(lo, 1);
    @(posedge mclk);
    reset_n <= 1'b0;
    #1;
    chk(lo, 0);
    @(posedge mclk);
    reset_n <= 1'b1;
    l1 <= 1'b0;
    rd(`LEM_ADDR_CFG, 32'h0);
  endtask

  // ==========
  // Verdict
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial
  begin
    #50000;
    n_mismatch++;
    finish_test();
  end

  initial
  begin
    n_mismatch = 0;
    num_checks = 0;
    reset_n = 1'b0;
    din = '0;
    cin = 1'b0;
    casc = 1'b0;
    l1 = 1'b0;
    l2 = 1'b0;
    tdat = 4'h0;
    ten = 4'h0;
    addr = 4'h0;
    wdat = 32'h0;
    wr_s = 1'b0;
    rd_s = 1'b0;
    repeat (16) @(posedge mclk);
    reset_n <= 1'b1;
    t_regs();
    t_norm();
    t_arith();
    t_pack();
    t_count();
    t_async();
    t_tri();
    t_rst();
    finish_test();
  end

endmodule

//--- lem_params.svh
// Offsets, field positions, reset values and widths of the logic cell
`ifndef LEM_PARAMS_SVH
`define LEM_PARAMS_SVH

// ==========================================================
// Register offsets (byte addresses)
`define LEM_ADDR_CFG 4'h0
`define LEM_ADDR_LUT 4'h4
`define LEM_ADDR_STAT 4'h8

// ==========================================================
// Reset values
`define LEM_CFG_RESET 12'h000
`define LEM_LUT_RESET 16'h0000
`define LEM_CHIP_RESET_VAL 1'b0

// ==========================================================
// Configuration register layout
`define LEM_CFG_W 12
`define LEM_F_MODE 1:0
`define LEM_F_CP 4:2
`define LEM_F_ENA_D1 5
`define LEM_F_CIN_D3 6
`define LEM_F_CASC 7
`define LEM_F_PACK 8
`define LEM_F_SWAP 9
`define LEM_F_PACK4 10
`define LEM_F_REGOUT 11

// ==========================================================
// Table layout and status width
`define LEM_LUT_W 16
`define LEM_CARRY_BASE 4'h8
`define LEM_STAT_W 5

`endif

//--- lem_pkg.sv
// Types shared by the logic cell
package lem_pkg;

  typedef enum logic [1:0] {
    lem_normal,
    lem_arith,
    lem_updown,
    lem_clrcnt
  } lem_mode_e;

  typedef enum logic [2:0] {
    lem_cp_clear,
    lem_cp_preset,
    lem_cp_clr_pre,
    lem_cp_load_clr,
    lem_cp_load_pre,
    lem_cp_load
  } lem_cp_e;

  typedef struct packed {
    logic fourth_data_input;
    logic third_data_input;
    logic second_data_input;
    logic first_data_input;
  } lem_data_s;

  typedef struct packed {
    logic clr_n;
    logic pre_n;
  } lem_async_s;

endpackage
